// ==== rtl/dsts_sequencer.sv ====
/*
 * Drive self-test sequencer: decodes the diagnostic command, steps the
 * electrical, servo and read/verify segments through an external test engine,
 * keeps a 20-entry results log and asks for it to be saved to non-volatile
 * storage after each change.
 * Assumes the test engine and the NV store run on clk; drive status pins and
 * the bus reset event come from other domains and are synchronised here.
 */
`include "dsts_defines.svh"
module dsts_sequencer
    import dsts_pkg::*;
#(
    parameter logic [33:0] SHORT_LIMIT_CYC = `DSTS_SHORT_LIMIT_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    // Command interface
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte1,
    output logic cmd_busy,
    // Unit-ready query
    input wire logic motor_spinning,
    input wire logic motor_at_speed,
    input wire logic servo_locked,
    input wire logic config_loaded,
    output logic not_ready,
    output logic [3:0] ready_sense_key,
    output logic [7:0] ready_asc,
    output logic [7:0] ready_ascq,
    output logic [15:0] ext_test_duration_s,
    // Aborts
    input wire logic bus_reset,
    input wire logic device_reset_msg,
    // Segment engine
    output logic seg_start,
    output dsts_seg_t seg_kind,
    output logic seg_retries_enabled,
    output logic seg_abort,
    input wire logic seg_done,
    input wire logic seg_fail,
    input wire logic [63:0] seg_fail_lba,
    input wire logic seg_lba_valid,
    input wire logic [3:0] seg_sense_key,
    input wire logic [7:0] seg_asc,
    input wire logic [7:0] seg_ascq,
    input wire logic [7:0] seg_fru,
    // Log read port and NV save
    input wire logic [4:0] log_rd_index,
    output logic [2:0] log_rd_func,
    output logic [3:0] log_rd_result,
    output logic [63:0] log_rd_lba,
    output logic [3:0] log_rd_sense_key,
    output logic [7:0] log_rd_asc,
    output logic [7:0] log_rd_ascq,
    output logic [7:0] log_rd_fru,
    output logic [4:0] log_count,
    output logic nv_save_req
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] async_in;

    assign async_in = {device_reset_msg, bus_reset, config_loaded, servo_locked,
                       motor_at_speed, motor_spinning};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    // ----------------------------------------------------------------
    // Readiness report
    // ----------------------------------------------------------------
    logic motor_bad;
    logic media_bad;
    logic reset_abort;

    assign motor_bad = !sync2_reg[0] || !sync2_reg[1];
    assign media_bad = !sync2_reg[2] || !sync2_reg[3];
    assign reset_abort = sync2_reg[4] || sync2_reg[5];

    logic not_ready_reg, not_ready_next;
    logic [7:0] ascq_reg, ascq_next;

    always_comb begin
        not_ready_next = motor_bad || media_bad;
        ascq_next = motor_bad ? `DSTS_ASCQ_MANUAL_INTERVENTION : `DSTS_ASCQ_CAUSE_UNKNOWN;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            not_ready_reg <= 1'b0;
            ascq_reg <= 8'h00;
        end else begin
            not_ready_reg <= not_ready_next;
            ascq_reg <= ascq_next;
        end
    end

    assign not_ready = not_ready_reg;
    assign ready_sense_key = not_ready_reg ? `DSTS_SK_NOT_READY : 4'h0;
    assign ready_asc = not_ready_reg ? `DSTS_ASC_NOT_READY : 8'h00;
    assign ready_ascq = not_ready_reg ? ascq_reg : 8'h00;
    assign ext_test_duration_s = `DSTS_EXT_DURATION_S_DEFAULT;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    logic [2:0] fc;
    logic start_short;
    logic start_ext;
    logic host_abort;

    assign fc = cmd_byte1[`DSTS_FC_MSB:`DSTS_FC_LSB];
    assign start_short = cmd_valid && fc == `DSTS_FC_SHORT;
    assign start_ext = cmd_valid && fc == `DSTS_FC_EXTENDED;
    assign host_abort = cmd_valid && fc == `DSTS_FC_ABORT;

    // ----------------------------------------------------------------
    // Sequencer and results log
    // ----------------------------------------------------------------
    dsts_state_t state_reg, state_next;
    logic ext_reg, ext_next;
    logic [33:0] timer_reg, timer_next;
    logic [3:0] result_reg, result_next;
    logic [4:0] count_reg, count_next;
    logic seg_start_reg, seg_start_next;
    logic seg_abort_reg, seg_abort_next;
    logic nv_reg, nv_next;

    logic [2:0] log_func_reg [`DSTS_LOG_DEPTH];
    logic [3:0] log_res_reg [`DSTS_LOG_DEPTH];
    logic [63:0] log_lba_reg [`DSTS_LOG_DEPTH];
    logic [31:0] log_sense_reg [`DSTS_LOG_DEPTH];

    logic do_shift;
    logic do_close;
    logic fail_capture;
    logic [31:0] fail_sense;
    logic [63:0] fail_lba;
    logic [2:0] new_func;

    assign fail_sense = {seg_sense_key, 4'h0, seg_asc, seg_ascq, seg_fru};
    assign fail_lba = seg_lba_valid ? seg_fail_lba : 64'hffff_ffff_ffff_ffff;

    always_comb begin
        state_next = state_reg;
        ext_next = ext_reg;
        timer_next = timer_reg;
        result_next = result_reg;
        count_next = count_reg;
        seg_start_next = 1'b0;
        seg_abort_next = 1'b0;
        nv_next = 1'b0;
        do_shift = 1'b0;
        do_close = 1'b0;
        fail_capture = 1'b0;
        new_func = start_ext ? `DSTS_FC_EXTENDED : `DSTS_FC_SHORT;
        case (state_reg)
            DSTS_IDLE: begin
                if ((start_short || start_ext) && !not_ready_reg) begin
                    ext_next = start_ext;
                    do_shift = 1'b1;
                    if (count_reg != `DSTS_LOG_DEPTH)
                        count_next = count_reg + 5'h01;
                    timer_next = 34'h0;
                    state_next = DSTS_LOG_NEW;
                end
            end
            DSTS_LOG_NEW: begin
                nv_next = 1'b1;
                seg_start_next = 1'b1;
                state_next = DSTS_ELEC;
            end
            DSTS_ELEC, DSTS_SERVO, DSTS_SCAN: begin
                timer_next = timer_reg + 34'h1;
                if (reset_abort) begin
                    result_next = `DSTS_RES_RESET_ABORT;
                    seg_abort_next = 1'b1;
                    state_next = DSTS_FINISH;
                end else if (host_abort) begin
                    result_next = `DSTS_RES_HOST_ABORT;
                    seg_abort_next = 1'b1;
                    state_next = DSTS_FINISH;
                end else if (!ext_reg && timer_reg >= SHORT_LIMIT_CYC) begin
                    result_next = `DSTS_RES_TIMEOUT;
                    seg_abort_next = 1'b1;
                    state_next = DSTS_FINISH;
                end else if (seg_done) begin
                    if (seg_fail) begin
                        fail_capture = 1'b1;
                        result_next = state_reg == DSTS_ELEC ? `DSTS_RES_ELEC_FAIL :
                                      state_reg == DSTS_SERVO ? `DSTS_RES_SERVO_FAIL :
                                      `DSTS_RES_SCAN_FAIL;
                        state_next = DSTS_FINISH;
                    end else if (state_reg == DSTS_SCAN) begin
                        result_next = `DSTS_RES_PASS;
                        state_next = DSTS_FINISH;
                    end else begin
                        seg_start_next = 1'b1;
                        state_next = state_reg == DSTS_ELEC ? DSTS_SERVO : DSTS_SCAN;
                    end
                end
            end
            DSTS_FINISH: begin
                do_close = 1'b1;
                nv_next = 1'b1;
                state_next = DSTS_IDLE;
            end
            default: state_next = DSTS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= DSTS_IDLE;
            ext_reg <= 1'b0;
            timer_reg <= 34'h0;
            result_reg <= `DSTS_RES_PASS;
            count_reg <= 5'h00;
            seg_start_reg <= 1'b0;
            seg_abort_reg <= 1'b0;
            nv_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ext_reg <= ext_next;
            timer_reg <= timer_next;
            result_reg <= result_next;
            count_reg <= count_next;
            seg_start_reg <= seg_start_next;
            seg_abort_reg <= seg_abort_next;
            nv_reg <= nv_next;
        end
    end

    // One entry per generate step; entry 0 is the newest
    for (genvar i = 0; i < `DSTS_LOG_DEPTH; i++) begin : g_log
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                log_func_reg[i] <= 3'h0;
                log_res_reg[i] <= `DSTS_RES_PASS;
                log_lba_reg[i] <= 64'h0;
                log_sense_reg[i] <= 32'h0;
            end else if (do_shift) begin
                if (i == 0) begin
                    log_func_reg[i] <= new_func;
                    log_res_reg[i] <= `DSTS_RES_BUSY;
                    log_lba_reg[i] <= 64'hffff_ffff_ffff_ffff;
                    log_sense_reg[i] <= 32'h0;
                end else begin
                    log_func_reg[i] <= log_func_reg[i - 1];
                    log_res_reg[i] <= log_res_reg[i - 1];
                    log_lba_reg[i] <= log_lba_reg[i - 1];
                    log_sense_reg[i] <= log_sense_reg[i - 1];
                end
            end else if (i == 0) begin
                if (do_close)
                    log_res_reg[i] <= result_reg;
                if (fail_capture) begin
                    log_lba_reg[i] <= fail_lba;
                    log_sense_reg[i] <= fail_sense;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic [4:0] rd_idx;

    assign rd_idx = log_rd_index > `DSTS_LOG_LAST ? `DSTS_LOG_LAST : log_rd_index;
    assign log_rd_func = log_func_reg[rd_idx];
    assign log_rd_result = log_res_reg[rd_idx];
    assign log_rd_lba = log_lba_reg[rd_idx];
    assign log_rd_sense_key = log_sense_reg[rd_idx][31:28];
    assign log_rd_asc = log_sense_reg[rd_idx][23:16];
    assign log_rd_ascq = log_sense_reg[rd_idx][15:8];
    assign log_rd_fru = log_sense_reg[rd_idx][7:0];
    assign log_count = count_reg;
    assign nv_save_req = nv_reg;
    assign cmd_busy = state_reg != DSTS_IDLE;
    assign seg_start = seg_start_reg;
    assign seg_abort = seg_abort_reg;
    assign seg_kind = state_reg == DSTS_SERVO ? DSTS_SEG_SERVO :
                      state_reg == DSTS_SCAN ? (ext_reg ? DSTS_SEG_FULL_SCAN :
                      DSTS_SEG_SHORT_SCAN) : DSTS_SEG_ELEC;
    assign seg_retries_enabled = 1'b1;

endmodule : dsts_sequencer

// ==== rtl/dsts_defines.svh ====
/*
 * Constants for the drive self-test sequencer: command codes, result values,
 * sense codes, log geometry and test timing.
 * Assumes inclusion by the package, the sequencer module and the testbench.
 */
// Overview of operation
// - Not-ready conditions answer 02/04/00 or 02/04/03.
// - Function code bits 7:5; 001 short, 010 extended.
// - Every test runs electrical, servo, read/verify segments.
// - Short test within 120 s, partial scan.
// - Extended test seeks, heads, full scan.
// - Extended duration reported in control page field.
// - New entry inserted at log head, others shift.
// - Log holds 20 entries, oldest discarded.
// - Entry starts with code and Fh, then saved.
// - Completion or abort overwrites entry result value.
// - Result 4 bits; zero pass, nonzero failure reason.
// - Failure records LBA, sense key, ASC, ASCQ, FRU.
// - Bus or device reset aborts running diagnostic.
// - Host abort code gives result 01.
// - Other aborts give result 02; a short-test timeout gives result 08.
// - Recovered errors never count as failures.
`ifndef DSTS_DEFINES_SVH
`define DSTS_DEFINES_SVH

`define DSTS_FC_SHORT 3'h1
`define DSTS_FC_EXTENDED 3'h2
`define DSTS_FC_ABORT 3'h4
`define DSTS_FC_LSB 5
`define DSTS_FC_MSB 7

`define DSTS_RES_PASS 4'h0
`define DSTS_RES_HOST_ABORT 4'h1
`define DSTS_RES_RESET_ABORT 4'h2
`define DSTS_RES_ELEC_FAIL 4'h3
`define DSTS_RES_SERVO_FAIL 4'h5
`define DSTS_RES_SCAN_FAIL 4'h7
`define DSTS_RES_TIMEOUT 4'h8
`define DSTS_RES_BUSY 4'hf

`define DSTS_SK_NOT_READY 4'h2
`define DSTS_ASC_NOT_READY 8'h04
`define DSTS_ASCQ_CAUSE_UNKNOWN 8'h00
`define DSTS_ASCQ_MANUAL_INTERVENTION 8'h03

`define DSTS_LOG_DEPTH 20
`define DSTS_LOG_IDX_W 5
`define DSTS_LOG_LAST 5'h13

`define DSTS_CLK_HZ 125000000
`define DSTS_SHORT_LIMIT_S 120
`define DSTS_SHORT_LIMIT_CYC (34'(`DSTS_SHORT_LIMIT_S) * 34'(`DSTS_CLK_HZ))
`define DSTS_EXT_DURATION_S_DEFAULT 16'h2a30

`endif

// ==== rtl/dsts_pkg.sv ====
/*
 * Types for the drive self-test sequencer.
 * Assumes the defines header sits on the include path.
 */
package dsts_pkg;

    `include "dsts_defines.svh"

    typedef enum logic [2:0] {
        DSTS_IDLE = 3'b000,
        DSTS_LOG_NEW = 3'b001,
        DSTS_ELEC = 3'b010,
        DSTS_SERVO = 3'b011,
        DSTS_SCAN = 3'b100,
        DSTS_FINISH = 3'b101
    } dsts_state_t;

    typedef enum logic [1:0] {
        DSTS_SEG_ELEC = 2'b00,
        DSTS_SEG_SERVO = 2'b01,
        DSTS_SEG_SHORT_SCAN = 2'b10,
        DSTS_SEG_FULL_SCAN = 2'b11
    } dsts_seg_t;

endpackage : dsts_pkg

// ==== test/dsts_sequencer_monitor.sv ====
/* Port checker for the self-test sequencer.
   Assumes it is bound to dsts_sequencer and that rstn is async low. */
module dsts_mon
    import dsts_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte1,
    input wire logic cmd_busy,
    input wire logic motor_spinning,
    input wire logic not_ready,
    input wire logic [3:0] ready_sense_key,
    input wire logic [7:0] ready_asc,
    input wire logic [7:0] ready_ascq,
    input wire logic bus_reset,
    input wire logic device_reset_msg,
    input wire logic seg_start,
    input wire dsts_seg_t seg_kind,
    input wire logic seg_retries_enabled,
    input wire logic seg_abort,
    input wire logic seg_done,
    input wire logic seg_fail,
    input wire logic [4:0] log_rd_index,
    input wire logic [2:0] log_rd_func,
    input wire logic [3:0] log_rd_result,
    input wire logic [4:0] log_count,
    input wire logic nv_save_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ----
    // Sequences and checks
    // ----
    sequence seq_start;
        cmd_valid && cmd_byte1[7:5] inside {3'h1, 3'h2} && !cmd_busy && !not_ready;
    endsequence
    sequence seq_scan_pass;
        seg_done && !seg_fail && cmd_busy && seg_kind inside {DSTS_SEG_SHORT_SCAN, DSTS_SEG_FULL_SCAN};
    endsequence
    chk_start_entry: assert property (seq_start |=> cmd_busy && (log_rd_index != 5'h00 ||
        (log_rd_result == 4'hf && log_rd_func == $past(cmd_byte1[7:5])))
        ##1 nv_save_req && seg_start && seg_kind == DSTS_SEG_ELEC) else $error("bad start");
    chk_count_sat: assert property (seq_start |=> log_count ==
        (($past(log_count) == 5'h14) ? 5'h14 : $past(log_count) + 5'h01)) else $error("bad count");
    chk_seg_order: assert property (seg_done && !seg_fail && cmd_busy &&
        seg_kind == DSTS_SEG_ELEC |=> seg_start && seg_kind == DSTS_SEG_SERVO) else $error("order");
    chk_pass_result: assert property (seq_scan_pass |-> ##2 (!cmd_busy && nv_save_req &&
        (log_rd_index != 5'h00 || log_rd_result == 4'h0))) else $error("pass result");
    chk_fail_code: assert property (seg_done && seg_fail && cmd_busy &&
        seg_kind == DSTS_SEG_ELEC |-> ##[1:3] (log_rd_index != 5'h00 || log_rd_result == 4'h3))
        else $error("fail code");
    chk_host_abort: assert property (cmd_valid && cmd_byte1[7:5] == 3'h4 && cmd_busy |=>
        seg_abort ##[1:2] (log_rd_index != 5'h00 || log_rd_result == 4'h1)) else $error("abort");
    chk_reset_abort: assert property (($rose(bus_reset) || $rose(device_reset_msg)) &&
        cmd_busy |-> ##[1:5] seg_abort) else $error("reset abort");
    chk_retry_on: assert property (seg_retries_enabled) else $error("retries off");
    chk_nr_code: assert property (not_ready |-> ready_sense_key == 4'h2 &&
        ready_asc == 8'h04 && ready_ascq inside {8'h00, 8'h03}) else $error("not ready code");
    chk_motor_nr: assert property (!motor_spinning [*5] |-> not_ready &&
        ready_ascq == 8'h03) else $error("motor code");
endmodule : dsts_mon

bind dsts_sequencer dsts_mon u_dsts_mon (.clk, .rstn, .cmd_valid, .cmd_byte1, .cmd_busy,
    .motor_spinning, .not_ready, .ready_sense_key, .ready_asc, .ready_ascq, .bus_reset,
    .device_reset_msg, .seg_start, .seg_kind, .seg_retries_enabled, .seg_abort, .seg_done,
    .seg_fail, .log_rd_index, .log_rd_func, .log_rd_result, .log_count, .nv_save_req);

// ==== test/dsts_seg_engine.sv ====
/* Segment engine model: answers each segment lat+1 cycles after its start.
   Assumes the sequencer clock; stall holds a segment open forever. */
module dsts_seg_engine
    import dsts_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic seg_start,
    input wire dsts_seg_t seg_kind,
    input wire logic seg_abort,
    input wire logic stall,
    input wire logic [7:0] lat,
    input wire logic fail_en,
    input wire dsts_seg_t fail_kind,
    output logic seg_done,
    output logic seg_fail,
    output logic [63:0] seg_fail_lba,
    output logic seg_lba_valid,
    output logic [3:0] seg_sense_key,
    output logic [7:0] seg_asc,
    output logic [7:0] seg_ascq,
    output logic [7:0] seg_fru
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_reg;
    logic [7:0] cnt_reg;
    logic [7:0] junk_reg;
    dsts_seg_t kind_reg;
    // ----
    // Answer and detail lines
    // ----
    // fails at done only when told; junk between answers
    assign seg_done = busy_reg && cnt_reg == 8'h00;
    assign seg_fail = seg_done ? (fail_en && kind_reg == fail_kind) : junk_reg[0];
    assign seg_fail_lba = seg_done ? 64'h0000_0000_00ab_cdef : {8{junk_reg}};
    // Only scan failures carry a block address
    assign seg_lba_valid = seg_done ?
        (kind_reg inside {DSTS_SEG_SHORT_SCAN, DSTS_SEG_FULL_SCAN}) : junk_reg[1];
    assign seg_sense_key = seg_done ? 4'h3 : junk_reg[3:0];
    assign seg_asc = seg_done ? 8'h11 : junk_reg;
    assign seg_ascq = seg_done ? 8'h05 : ~junk_reg;
    assign seg_fru = seg_done ? 8'h7e : junk_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_reg <= 1'b0;
            cnt_reg <= 8'h00;
            kind_reg <= DSTS_SEG_ELEC;
            junk_reg <= 8'h5a;
        end else begin
            junk_reg <= junk_reg + 8'h3b;
            if (seg_abort || seg_done) begin
                busy_reg <= 1'b0;
            end else if (seg_start) begin
                busy_reg <= !stall;
                cnt_reg <= lat;
                kind_reg <= seg_kind;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule : dsts_seg_engine

// ==== test/dsts_sequencer_tb.sv ====
/* Self-checking bench for the self-test sequencer.
   Assumes the monitor bind and the segment engine model are compiled. */
`include "dsts_defines.svh"
module dsts_sequencer_tb
    import dsts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, cmd_valid, cmd_busy, not_ready, bus_reset, device_reset_msg, nv_save_req;
    logic motor_spinning, motor_at_speed, servo_locked, config_loaded, stall, fail_en, f;
    logic seg_start, seg_retries_enabled, seg_abort, seg_done, seg_fail, seg_lba_valid;
    logic [7:0] cmd_byte1, ready_asc, ready_ascq, seg_asc, seg_ascq, seg_fru, lat;
    logic [7:0] log_rd_asc, log_rd_ascq, log_rd_fru;
    logic [3:0] ready_sense_key, seg_sense_key, log_rd_result, log_rd_sense_key;
    logic [15:0] ext_test_duration_s;
    logic [63:0] seg_fail_lba, log_rd_lba;
    logic [4:0] log_rd_index, log_count;
    logic [2:0] log_rd_func, fc;
    logic [31:0] rng = 32'h50, r;
    logic [2:0] hist [0:19];
    dsts_seg_t seg_kind, fail_kind, k;
    int fails = 0, n_checks = 0, n_log = 0;
    dsts_sequencer #(.SHORT_LIMIT_CYC(34'h0c8)) u_dsts_sequencer (.clk, .rstn, .cmd_valid,
        .cmd_byte1, .cmd_busy, .motor_spinning, .motor_at_speed, .servo_locked, .config_loaded,
        .not_ready, .ready_sense_key, .ready_asc, .ready_ascq, .ext_test_duration_s, .bus_reset,
        .device_reset_msg, .seg_start, .seg_kind, .seg_retries_enabled, .seg_abort, .seg_done,
        .seg_fail, .seg_fail_lba, .seg_lba_valid, .seg_sense_key, .seg_asc, .seg_ascq, .seg_fru,
        .log_rd_index, .log_rd_func, .log_rd_result, .log_rd_lba, .log_rd_sense_key, .log_rd_asc,
        .log_rd_ascq, .log_rd_fru, .log_count, .nv_save_req);
    dsts_seg_engine u_dsts_seg_engine (.clk, .rstn, .seg_start, .seg_kind, .seg_abort, .stall,
        .lat, .fail_en, .fail_kind, .seg_done, .seg_fail, .seg_fail_lba, .seg_lba_valid,
        .seg_sense_key, .seg_asc, .seg_ascq, .seg_fru);
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    function automatic logic [3:0] exp_res(input logic fl, input dsts_seg_t kd);
        if (!fl) return `DSTS_RES_PASS;
        return kd == DSTS_SEG_ELEC ? 4'h3 : (kd == DSTS_SEG_SERVO ? 4'h5 : 4'h7);
    endfunction : exp_res
    task automatic close_out();
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic send(input logic [2:0] c);
        r = xs();
        cmd_byte1 = {c, r[4:0]};
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
        tick(1);
    endtask : send
    task automatic begin_test(input logic [2:0] c);
        send(c);
        for (int i = 19; i > 0; i--) hist[i] = hist[i - 1];
        hist[0] = c;
        n_log++;
        cmp(cmd_busy, 1'b1, "busy");
        cmp(log_rd_result, `DSTS_RES_BUSY, "in progress");
        cmp(log_count, (n_log > 20) ? 20 : n_log, "count");
    endtask : begin_test
    task automatic end_test(input logic [2:0] c, input logic [3:0] exp, input logic fl);
        for (int i = 0; i < 3000 && cmd_busy !== 1'b0; i++) tick(1);
        tick(2);
        cmp(cmd_busy, 1'b0, "hang");
        cmp(log_rd_result, exp, "result");
        cmp(log_rd_func, c, "func");
        if (fl) begin
            cmp({log_rd_sense_key, log_rd_asc, log_rd_ascq, log_rd_fru},
                {4'h3, 8'h11, 8'h05, 8'h7e}, "sense");
            cmp(log_rd_lba, (exp == `DSTS_RES_SCAN_FAIL) ? 64'h00ab_cdef :
                64'hffff_ffff_ffff_ffff, "lba");
        end
    endtask : end_test
    task automatic run(input logic [2:0] c, input logic [7:0] l, input logic fl,
                       input dsts_seg_t kd, input logic [3:0] exp);
        lat = l;
        fail_en = fl;
        fail_kind = kd;
        begin_test(c);
        end_test(c, exp, fl);
    endtask : run
    // ----
    // Main sequence
    // ----
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        close_out();
    end
    initial begin
        rstn = 1'b0;
        {cmd_valid, cmd_byte1, bus_reset, device_reset_msg, stall, fail_en, lat} = '0;
        {motor_spinning, motor_at_speed, servo_locked, config_loaded} = 4'hf;
        fail_kind = DSTS_SEG_ELEC;
        log_rd_index = 5'h00;
        tick(20);
        rstn = 1'b1;
        tick(3);
        cmp({not_ready, ready_sense_key}, 5'h00, "ready");
        cmp(ext_test_duration_s, `DSTS_EXT_DURATION_S_DEFAULT, "duration");
        cmp(seg_retries_enabled, 1'b1, "retries");
        for (int p = 0; p < 4; p++) begin
            {motor_spinning, motor_at_speed, servo_locked, config_loaded} = ~(4'h8 >> p);
            tick(4);
            cmp({ready_sense_key, ready_asc, ready_ascq},
                {4'h2, 8'h04, (p < 2) ? 8'h03 : 8'h00}, "not ready");
            send(3'h1);
            cmp(cmd_busy, 1'b0, "start refused");
        end
        {motor_spinning, motor_at_speed, servo_locked, config_loaded} = 4'hf;
        tick(4);
        send(3'h4);
        cmp(cmd_busy, 1'b0, "idle abort");
        run(3'h1, 8'h00, 1'b0, DSTS_SEG_ELEC, `DSTS_RES_PASS);
        run(3'h1, 8'h64, 1'b0, DSTS_SEG_ELEC, `DSTS_RES_TIMEOUT);
        run(3'h2, 8'h64, 1'b0, DSTS_SEG_ELEC, `DSTS_RES_PASS);
        for (int t = 0; t < 22; t++) begin
            r = xs();
            fc = r[0] ? 3'h2 : 3'h1;
            f = r[3:2] == 2'b00;
            k = dsts_seg_t'((r[5:4] == 2'b11) ? 2'b10 : r[5:4]);
            if (k == DSTS_SEG_SHORT_SCAN && fc == 3'h2) k = DSTS_SEG_FULL_SCAN;
            run(fc, {3'h0, r[12:8]}, f, k, exp_res(f, k));
        end
        for (int h = 0; h < 3; h++) begin
            stall = 1'b1;
            fail_en = 1'b0;
            begin_test(3'h2);
            tick(6);
            send(3'h1);
            cmp(log_count, 5'h14, "busy start");
            if (h == 0) send(3'h4);
            else {bus_reset, device_reset_msg} = (h == 1) ? 2'b10 : 2'b01;
            tick(3);
            {bus_reset, device_reset_msg} = 2'b00;
            end_test(3'h2, (h == 0) ? `DSTS_RES_HOST_ABORT : `DSTS_RES_RESET_ABORT, 1'b0);
        end
        stall = 1'b0;
        for (int i = 0; i < 20; i++) begin
            log_rd_index = i[4:0];
            tick(1);
            cmp(log_rd_func, hist[i], "log order");
        end
        close_out();
    end
endmodule : dsts_sequencer_tb
